//--- rtl/eea_dev_end.sv
// Contract
// - start only from idle bus, both high
// - one bit per clock, stable while high
// - data falling, clock high means START
// - data rising, clock high means STOP
// - ninth acknowledge bit follows every byte
// - answer only target address 0x50
// - 16384 bytes behind 14-bit address
// - 32-byte page buffer, single bytes too
// - erase happens inside program cycle
// - master polls readiness until program ends
// - two address bytes, each acknowledged low
// - data byte received, then acknowledged low
// - master ends byte write with STOP
// - STOP starts program cycle, 6 ms max
// - power-down input low halts the device; a program cycle already running still completes
// - write-protect input blocks programming
// - register and array reachable only by bus
// - bus works up to 400 kHz
// - ignore bus during program cycle
// - no address acknowledge while programming
// - page bytes wrap within page
// - sequential read advances, wraps at 0x3FFF
`timescale 1ns/1ps
`default_nettype none
`include "eea_consts.svh"
module eea_dev_end #(
   parameter int ADDR_W      = `EEA_ADDR_W,
   parameter int PAGE_W      = `EEA_PAGE_W,
   parameter int PROG_CYCLES = `EEA_PROG_CYCLES
) (
   // clock and reset
   input  wire logic   REF_CLK_I,
   input  wire logic   RST_N_I,
   // bus pins
   eea_link_if.dev     LINK,
   // system controls
   input  wire logic   POWER_DOWN_N_IN_I,
   input  wire logic   WRITE_PROTECT_I,
   // status
   output logic        BUSY_O
);
   import eea_pkg::*;

   localparam int PAGE_BYTES = 1 << PAGE_W;
   localparam int PCW        = $clog2(PROG_CYCLES + 1);
   function automatic logic [ADDR_W-1:0] inc_addr(input logic [ADDR_W-1:0] a);
      return ADDR_W'(a + 1'b1);
   endfunction
   eea_phase_t          phase;
   logic [1:0]          sync1;
   logic [1:0]          sync2;
   logic [1:0]          hist0;
   logic [1:0]          hist1;
   logic [1:0]          filt;
   logic [1:0]          filt_q;
   logic [1:0]          same;
   logic                scl_f;
   logic                sda_f;
   logic                scl_q;
   logic                sda_q;
   logic                scl_rise;
   logic                scl_fall;
   logic                start_ev;
   logic                stop_ev;
   logic [3:0]          bit_cnt;
   logic [7:0]          shreg;
   logic [7:0]          tx;
   logic [ADDR_W-1:0]   addr;
   logic [ADDR_W-1:0]   next_addr;
   logic                sda_oe_n;
   logic                mack;
   logic                addr_match;
   logic                ack_end;
   logic                wr_strobe;
   logic                adrl_strobe;
   logic [PCW-1:0]      prog_cnt;
   logic                prog_last;
   logic                prog_wr;
   logic [PAGE_W-1:0]   prog_idx;
   logic [PAGE_BYTES-1:0] valid;
   logic [7:0]          pbuf [0:PAGE_BYTES-1];
   logic [7:0]          mem  [0:(1<<ADDR_W)-1];
   logic [7:0]          rd_cur;
   logic [7:0]          rd_next;

   ////////////////////////////////////////////////////////////////////////////////
   // three-sample filter; about 5 cycles of latency, well inside the 6-cycle high
   // time at the top rate, so short spikes never reach the edge logic
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sync1  <= `EEA_LINE_IDLE;
         sync2  <= `EEA_LINE_IDLE;
         hist0  <= `EEA_LINE_IDLE;
         hist1  <= `EEA_LINE_IDLE;
         filt   <= `EEA_LINE_IDLE;
         filt_q <= `EEA_LINE_IDLE;
      end else begin
         sync1  <= {LINK.scl, LINK.sda};
         sync2  <= sync1;
         hist0  <= sync2;
         hist1  <= hist0;
         filt   <= (filt & ~same) | (sync2 & same);
         filt_q <= filt;
      end
   end
   assign same     = ~(sync2 ^ hist0) & ~(hist0 ^ hist1);
   assign scl_f    = filt[1];
   assign sda_f    = filt[0];
   assign scl_q    = filt_q[1];
   assign sda_q    = filt_q[0];
   assign scl_rise = scl_f & ~scl_q;
   assign scl_fall = ~scl_f & scl_q;
   assign start_ev = scl_f & scl_q & sda_q & ~sda_f;
   assign stop_ev  = scl_f & scl_q & ~sda_q & sda_f;
   ////////////////////////////////////////////////////////////////////////////////
   // byte engine
   assign addr_match  = (shreg[7:1] == `EEA_DEV_ADDR);
   assign next_addr   = inc_addr(addr);
   assign rd_cur      = mem[addr];
   assign rd_next     = mem[next_addr];
   assign ack_end     = (phase != PH_PROG) && POWER_DOWN_N_IN_I && scl_fall && (bit_cnt == 4'h8);
   assign wr_strobe   = ack_end && (phase == PH_WDATA);
   assign adrl_strobe = ack_end && (phase == PH_ADRL);
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         phase    <= PH_IDLE;
         bit_cnt  <= 4'h0;
         shreg    <= 8'h00;
         tx       <= 8'h00;
         addr     <= '0;
         sda_oe_n <= 1'b1;
         mack     <= 1'b0;
      end else if (phase == PH_PROG) begin
         sda_oe_n <= 1'b1;
         if (prog_last) begin
            phase <= PH_IDLE;
         end
      end else if (!POWER_DOWN_N_IN_I) begin
         phase    <= PH_IDLE;
         sda_oe_n <= 1'b1;
      end else if (start_ev) begin
         phase    <= PH_DEVADR;
         bit_cnt  <= 4'hF;
         sda_oe_n <= 1'b1;
      end else if (stop_ev) begin
         sda_oe_n <= 1'b1;
         // a write that reached no data byte, or is protected, just ends
         if (phase == PH_WDATA && (|valid) && (WRITE_PROTECT_I != `EEA_WP_ACTIVE)) begin
            phase <= PH_PROG;
         end else begin
            phase <= PH_IDLE;
         end
      end else if (phase != PH_IDLE) begin
         if (scl_rise && bit_cnt < 4'h8) begin
            shreg <= {shreg[6:0], sda_f};
         end
         if (scl_rise && bit_cnt == 4'h8) begin
            mack <= ~sda_f;
         end
         if (scl_fall) begin
            if (bit_cnt == 4'hF) begin
               bit_cnt <= 4'h0;                           // clock fall after start carries no bit
            end else if (bit_cnt < 4'h7) begin
               bit_cnt <= 4'(bit_cnt + 1'b1);
               if (phase == PH_RDATA) begin
                  tx       <= {tx[6:0], 1'b0};
                  sda_oe_n <= tx[6];
               end
            end else if (bit_cnt == 4'h7) begin
               bit_cnt <= 4'h8;
               if (phase == PH_RDATA) begin
                  sda_oe_n <= 1'b1;
               end else begin
                  sda_oe_n <= (phase == PH_DEVADR) ? ~addr_match : 1'b0;
               end
            end else begin
               bit_cnt <= 4'h0;
               unique case (phase)
                  PH_DEVADR: begin
                     if (!addr_match) begin
                        phase    <= PH_IDLE;
                        sda_oe_n <= 1'b1;
                     end else if (shreg[0] == `EEA_DIR_READ) begin
                        phase    <= PH_RDATA;
                        tx       <= rd_cur;
                        sda_oe_n <= rd_cur[7];
                     end else begin
                        phase    <= PH_ADRH;
                        sda_oe_n <= 1'b1;
                     end
                  end
                  PH_ADRH: begin
                     addr[ADDR_W-1:8] <= shreg[ADDR_W-9:0];
                     phase            <= PH_ADRL;
                     sda_oe_n         <= 1'b1;
                  end
                  PH_ADRL: begin
                     addr[7:0] <= shreg;
                     phase     <= PH_WDATA;
                     sda_oe_n  <= 1'b1;
                  end
                  PH_WDATA: begin
                     addr     <= {addr[ADDR_W-1:PAGE_W], PAGE_W'(addr[PAGE_W-1:0] + 1'b1)};
                     sda_oe_n <= 1'b1;
                  end
                  PH_RDATA: begin
                     if (mack) begin
                        addr     <= next_addr;
                        tx       <= rd_next;
                        sda_oe_n <= rd_next[7];
                     end else begin
                        phase    <= PH_IDLE;
                        sda_oe_n <= 1'b1;
                     end
                  end
                  default: begin
                     phase    <= PH_IDLE;
                     sda_oe_n <= 1'b1;
                  end
               endcase
            end
         end
      end else begin
         sda_oe_n <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // page buffer; only bytes actually received are programmed
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         valid <= '0;
      end else if (prog_last || adrl_strobe) begin
         valid <= '0;
      end else if (wr_strobe) begin
         valid[addr[PAGE_W-1:0]] <= 1'b1;
      end
   end
   always_ff @(posedge REF_CLK_I) begin
      if (wr_strobe) begin
         pbuf[addr[PAGE_W-1:0]] <= shreg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // self-timed program cycle; the copy takes the first page-size cycles
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         prog_cnt <= '0;
      end else if (phase == PH_PROG && !prog_last) begin
         prog_cnt <= PCW'(prog_cnt + 1'b1);
      end else begin
         prog_cnt <= '0;
      end
   end
   assign prog_last = (phase == PH_PROG) && (prog_cnt == PCW'(PROG_CYCLES - 1));
   assign prog_idx  = prog_cnt[PAGE_W-1:0];
   assign prog_wr   = (phase == PH_PROG) && (prog_cnt < PCW'(PAGE_BYTES)) && valid[prog_idx];
   // array has no reset: contents survive reset and power-down
   always_ff @(posedge REF_CLK_I) begin
      if (prog_wr) begin
         mem[{addr[ADDR_W-1:PAGE_W], prog_idx}] <= pbuf[prog_idx];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   assign LINK.dev_sda_o    = 1'b0;
   assign LINK.dev_sda_oe_n = sda_oe_n;
   assign BUSY_O            = (phase == PH_PROG);
endmodule
`default_nettype wire

//--- shared/eea_consts.svh
`ifndef EEA_CONSTS_SVH
`define EEA_CONSTS_SVH
// target address and its two direction bits
`define EEA_DEV_ADDR        7'h50
`define EEA_DIR_WRITE       1'b0
`define EEA_DIR_READ        1'b1
// array and page geometry
`define EEA_ADDR_W          14
`define EEA_PAGE_W          5
// clock rate and self-timed program cycle
`define EEA_CLK_HZ          10000000
`define EEA_PROG_MS         6
`define EEA_PROG_CYCLES     (`EEA_PROG_MS * (`EEA_CLK_HZ / 1000))
// highest bus clock rate the target must follow
`define EEA_SCL_MAX_KHZ     400
// host divider: four quarters per bus clock, 8 x 100 ns each gives 312.5 kHz
`define EEA_HOST_QTR_CYCLES 8
// level of the write-protect input that blocks programming
`define EEA_WP_ACTIVE       1'b1
// reset level of a released bus line
`define EEA_LINE_IDLE       2'h3
`endif

//--- shared/eea_pkg.sv
package eea_pkg;
   typedef enum logic [2:0] {
      PH_IDLE   = 3'b000,
      PH_DEVADR = 3'b001,
      PH_ADRH   = 3'b010,
      PH_ADRL   = 3'b011,
      PH_WDATA  = 3'b100,
      PH_RDATA  = 3'b101,
      PH_PROG   = 3'b110
   } eea_phase_t;

   typedef enum logic [2:0] {
      OP_START = 3'b000,
      OP_TX    = 3'b001,
      OP_RX    = 3'b010,
      OP_STOP  = 3'b011,
      OP_END   = 3'b100
   } eea_op_t;

   typedef enum logic {
      CMD_WRITE = 1'b0,
      CMD_READ  = 1'b1
   } eea_cmd_t;
endpackage

//--- shared/eea_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eea_link_if;
   logic host_scl_o;
   logic host_scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic scl;
   logic sda;

   // wired-and: a released line is pulled high
   assign scl = host_scl_oe_n | host_scl_o;
   assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

   modport dev (
      input  scl,
      input  sda,
      output dev_sda_o,
      output dev_sda_oe_n
   );

   modport host (
      input  scl,
      input  sda,
      output host_scl_o,
      output host_scl_oe_n,
      output host_sda_o,
      output host_sda_oe_n
   );
endinterface
`default_nettype wire

//--- rtl/eea_host_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "eea_consts.svh"
module eea_host_end #(
   parameter int QTR_CYCLES = `EEA_HOST_QTR_CYCLES
) (
   // clock and reset
   input  wire logic              REF_CLK_I,
   input  wire logic              RST_N_I,
   // bus pins
   eea_link_if.host               LINK,
   // command
   input  wire logic              CMD_VALID_I,
   output logic                   CMD_READY_O,
   input  wire eea_pkg::eea_cmd_t CMD_KIND_I,
   input  wire logic [13:0]       CMD_ADDR_I,
   input  wire logic [7:0]        CMD_DATA_I,
   // answer
   output logic                   DONE_O,
   output logic                   NACK_O,
   output logic [7:0]             RD_DATA_O
);
   import eea_pkg::*;

   localparam int QW = $clog2(QTR_CYCLES);

   // write: S A0 AH AL D P, then poll S A0 P until acknowledged
   // read : S A0 AH AL S A1 byte P
   function automatic eea_op_t op_of(input eea_cmd_t k, input logic [3:0] s);
      if (k == CMD_WRITE) begin
         unique case (s)
            4'h0, 4'h6:               return OP_START;
            4'h1, 4'h2, 4'h3, 4'h4, 4'h7: return OP_TX;
            4'h5, 4'h8:               return OP_STOP;
            default:                  return OP_END;
         endcase
      end
      unique case (s)
         4'h0, 4'h4:               return OP_START;
         4'h1, 4'h2, 4'h3, 4'h5:   return OP_TX;
         4'h6:                     return OP_RX;
         4'h7:                     return OP_STOP;
         default:                  return OP_END;
      endcase
   endfunction

   function automatic logic [7:0] byte_of(input eea_cmd_t k, input logic [3:0] s,
                                          input logic [13:0] a, input logic [7:0] d);
      unique case (s)
         4'h2:    return {2'h0, a[13:8]};
         4'h3:    return a[7:0];
         4'h4:    return d;
         4'h5:    return {`EEA_DEV_ADDR, `EEA_DIR_READ};
         default: return {`EEA_DEV_ADDR, `EEA_DIR_WRITE};
      endcase
   endfunction

   logic          busy;
   eea_cmd_t      kind;
   logic [13:0]   addr_q;
   logic [7:0]    data_q;
   logic [3:0]    step;
   logic [QW-1:0] qcnt;
   logic          tick;
   logic [1:0]    qph;
   logic [3:0]    bcnt;
   logic [7:0]    sh;
   logic [7:0]    cur;
   logic          scl_oe_n;
   logic          sda_oe_n;
   logic          got_ack;
   logic          poll_ok;
   logic          nack;
   eea_op_t       op;

   ////////////////////////////////////////////////////////////////////////////////
   // quarter-period divider; the bus clock is made here
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         qcnt <= '0;
      end else if (!busy || tick) begin
         qcnt <= '0;
      end else begin
         qcnt <= QW'(qcnt + 1'b1);
      end
   end

   assign tick = busy && (qcnt == QW'(QTR_CYCLES - 1));
   assign op   = op_of(kind, step);
   assign cur  = (bcnt == 4'h0) ? byte_of(kind, step, addr_q, data_q) : sh;

   ////////////////////////////////////////////////////////////////////////////////
   // bit sequencer: data changes in quarter 0, clock high in quarters 1 and 2
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         busy      <= 1'b0;
         kind      <= CMD_WRITE;
         addr_q    <= 14'h0000;
         data_q    <= 8'h00;
         step      <= 4'h0;
         qph       <= 2'h0;
         bcnt      <= 4'h0;
         sh        <= 8'h00;
         scl_oe_n  <= 1'b1;
         sda_oe_n  <= 1'b1;
         got_ack   <= 1'b0;
         poll_ok   <= 1'b0;
         nack      <= 1'b0;
         DONE_O    <= 1'b0;
         NACK_O    <= 1'b0;
         RD_DATA_O <= 8'h00;
      end else begin
         DONE_O <= 1'b0;
         if (!busy) begin
            if (CMD_VALID_I) begin
               busy   <= 1'b1;
               kind   <= CMD_KIND_I;
               addr_q <= CMD_ADDR_I;
               data_q <= CMD_DATA_I;
               step   <= 4'h0;
               qph    <= 2'h0;
               bcnt   <= 4'h0;
               nack   <= 1'b0;
            end
         end else if (tick) begin
            qph <= 2'(qph + 1'b1);
            unique case (op)
               OP_START: begin
                  unique case (qph)
                     2'h0: sda_oe_n <= 1'b1;
                     2'h1: scl_oe_n <= 1'b1;
                     2'h2: begin
                        if (step == 4'h0 && !(LINK.scl && LINK.sda)) begin
                           qph <= qph;
                        end else begin
                           sda_oe_n <= 1'b0;
                        end
                     end
                     2'h3: begin
                        scl_oe_n <= 1'b0;
                        step     <= 4'(step + 1'b1);
                     end
                  endcase
               end
               OP_TX, OP_RX: begin
                  unique case (qph)
                     2'h0: begin
                        if (op == OP_TX) begin
                           sda_oe_n <= (bcnt == 4'h8) ? 1'b1 : cur[7];
                           sh       <= {cur[6:0], 1'b0};
                        end else begin
                           sda_oe_n <= 1'b1;              // single read ends with no acknowledge
                        end
                     end
                     2'h1: scl_oe_n <= 1'b1;
                     2'h2: begin
                        if (op == OP_TX && bcnt == 4'h8) begin
                           got_ack <= ~LINK.sda;
                        end
                        if (op == OP_RX && bcnt < 4'h8) begin
                           sh <= {sh[6:0], LINK.sda};
                        end
                     end
                     2'h3: begin
                        scl_oe_n <= 1'b0;
                        bcnt     <= 4'(bcnt + 1'b1);
                        if (bcnt == 4'h8) begin
                           bcnt <= 4'h0;
                           if (op == OP_RX) begin
                              RD_DATA_O <= sh;
                              step      <= 4'(step + 1'b1);
                           end else if (kind == CMD_WRITE && step == 4'h7) begin
                              poll_ok <= got_ack;
                              step    <= 4'h8;
                           end else if (!got_ack) begin
                              nack <= 1'b1;
                              step <= (kind == CMD_WRITE) ? 4'h5 : 4'h7;
                           end else begin
                              step <= 4'(step + 1'b1);
                           end
                        end
                     end
                  endcase
               end
               OP_STOP: begin
                  unique case (qph)
                     2'h0: sda_oe_n <= 1'b0;
                     2'h1: scl_oe_n <= 1'b1;
                     2'h2: sda_oe_n <= 1'b1;
                     2'h3: begin
                        if (kind == CMD_READ) begin
                           step <= 4'h8;
                        end else if (step == 4'h5) begin
                           step <= nack ? 4'h9 : 4'h6;
                        end else begin
                           step <= poll_ok ? 4'h9 : 4'h6;
                        end
                     end
                  endcase
               end
               OP_END: begin
                  busy   <= 1'b0;
                  DONE_O <= 1'b1;
                  NACK_O <= nack;
               end
               default: begin
                  busy <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign CMD_READY_O        = ~busy;
   assign LINK.host_scl_o    = 1'b0;
   assign LINK.host_scl_oe_n = scl_oe_n;
   assign LINK.host_sda_o    = 1'b0;
   assign LINK.host_sda_oe_n = sda_oe_n;
endmodule
`default_nettype wire

//--- verification/eea_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module eea_link_asserts #(
   parameter int PROG_CYCLES = 100
) (
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   // wire levels and device drive
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_oe_n,
   // device controls and status
   input wire logic POWER_DOWN_N_IN_I,
   input wire logic WRITE_PROTECT_I,
   input wire logic BUSY_O
);
   int   busy_cnt;
   int   since_stop;
   logic scl_q;
   logic sda_q;
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);
   ////////////////////////////////////////////////////////////////////////////////
   // raw stop seen on the wire; the device filter adds a few cycles on top
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         since_stop <= 1000;
      end else if (scl && scl_q && sda && !sda_q) begin
         since_stop <= 0;
      end else if (since_stop < 1000) begin
         since_stop <= since_stop + 1;
      end
   end
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= BUSY_O ? busy_cnt + 1 : 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   AST_DEV_SDA_ONLY_SCL_LOW: assert property (!$stable(dev_sda_oe_n) |-> !scl)
      else $error("device moved data while clock high");
   AST_ACK_BOUNDED: assert property ($fell(dev_sda_oe_n) |-> ##[1:400] dev_sda_oe_n)
      else $error("device held data low too long");
   AST_PROG_AFTER_STOP: assert property ($rose(BUSY_O) |-> since_stop <= 12)
      else $error("program cycle began without a stop");
   AST_PROG_LENGTH: assert property ($fell(BUSY_O) |-> busy_cnt inside {[PROG_CYCLES-4:PROG_CYCLES+4]})
      else $error("program cycle length wrong");
   AST_QUIET_WHILE_BUSY: assert property (BUSY_O |-> dev_sda_oe_n)
      else $error("device drove bus while programming");
   AST_PROTECT_BLOCKS: assert property ($rose(BUSY_O) |-> !WRITE_PROTECT_I)
      else $error("program cycle while protected");
   AST_PWDN_RELEASE: assert property (!POWER_DOWN_N_IN_I [*2] |-> dev_sda_oe_n)
      else $error("device drove bus in power down");
   AST_PWDN_NO_PROG: assert property ($rose(BUSY_O) |-> POWER_DOWN_N_IN_I)
      else $error("program cycle began in power down");
   // the filter delay means no reaction in the first cycles after a clock fall
   AST_FILTER_DELAY: assert property ($fell(scl) |=> $stable(dev_sda_oe_n) [*3])
      else $error("device reacted before filter delay");
   COV_PROG: cover property ($rose(BUSY_O));
   COV_DEV_DRIVE: cover property ($fell(dev_sda_oe_n));
   COV_PROG_END: cover property ($fell(BUSY_O));
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import eea_pkg::*;
   localparam int PROG = 100;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        valid = 1'b0;
   eea_cmd_t    kind = CMD_WRITE;
   logic [13:0] addr = 14'h0000;
   logic [7:0]  data = 8'h00;
   logic        pd_n = 1'b1;
   logic        wp = 1'b0;
   logic        busy_seen = 1'b0;
   logic        ready;
   logic        done;
   logic        nack;
   logic        busy;
   logic [7:0]  rdata;
   logic [13:0] adr [3] = '{14'h3FFF, 14'h0000, 14'h1555};
   int          error_cnt = 0;
   int          checked = 0;
   eea_link_if link ();
   always #50 clk = ~clk;
   always @(posedge clk) if (busy === 1'b1) busy_seen <= 1'b1;
   eea_dev_end #(.PROG_CYCLES(PROG)) eea_dev_end_inst (.REF_CLK_I(clk), .RST_N_I(rst_n),
      .LINK(link), .POWER_DOWN_N_IN_I(pd_n), .WRITE_PROTECT_I(wp), .BUSY_O(busy));
   eea_host_end #(.QTR_CYCLES(8)) eea_host_end_inst (.REF_CLK_I(clk), .RST_N_I(rst_n),
      .LINK(link), .CMD_VALID_I(valid), .CMD_READY_O(ready), .CMD_KIND_I(kind),
      .CMD_ADDR_I(addr), .CMD_DATA_I(data), .DONE_O(done), .NACK_O(nack), .RD_DATA_O(rdata));
   eea_link_asserts #(.PROG_CYCLES(PROG)) eea_link_asserts_inst (.REF_CLK_I(clk),
      .RST_N_I(rst_n), .scl(link.scl), .sda(link.sda), .dev_sda_oe_n(link.dev_sda_oe_n),
      .POWER_DOWN_N_IN_I(pd_n), .WRITE_PROTECT_I(wp), .BUSY_O(busy));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("compares %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one command, held until taken, then bounded wait for the completion pulse
   task automatic run(input eea_cmd_t k, input logic [13:0] a, input logic [7:0] d);
      int n;
      n = 0;
      while (ready !== 1'b1) @(posedge clk);
      busy_seen = 1'b0;
      valid <= 1'b1;
      kind <= k;
      addr <= a;
      data <= d;
      @(posedge clk);
      valid <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (done !== 1'b1 && n < 20000);
      if (n >= 20000) begin
         error_cnt++;
         $display("mismatch done expected 1 seen 0");
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (adr[i]) begin
         run(CMD_WRITE, adr[i], adr[i][7:0] ^ 8'h3C);
         check("write nack", 8'h00, {7'h00, nack});
         check("program seen", 8'h01, {7'h00, busy_seen});
      end
      foreach (adr[i]) begin
         run(CMD_READ, adr[i], 8'h00);
         check("read data", adr[i][7:0] ^ 8'h3C, rdata);
      end
      wp <= 1'b1;
      run(CMD_WRITE, 14'h0000, 8'hFF);
      check("protected program", 8'h00, {7'h00, busy_seen});
      wp <= 1'b0;
      run(CMD_READ, 14'h0000, 8'h00);
      check("protected data", 8'h3C, rdata);
      pd_n <= 1'b0;
      run(CMD_READ, 14'h3FFF, 8'h00);
      check("power down nack", 8'h01, {7'h00, nack});
      pd_n <= 1'b1;
      run(CMD_READ, 14'h3FFF, 8'h00);
      check("resume data", 8'hC3, rdata);
      test_done();
   end
   // a hung handshake must still end the run with a verdict
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      $display("mismatch watchdog expected finish seen timeout");
      test_done();
   end
endmodule
`default_nettype wire
